// ===== hdl/fsc_pkg.sv
`default_nettype none
package fsc_pkg;
   // clock and pin timing
   localparam int CLK_NS     = 40;
   localparam int STROBE_NS  = 160;
   localparam int RECOV_NS   = 40;
   localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
   localparam int RECOV_CYC  = (RECOV_NS + CLK_NS - 1) / CLK_NS;
   localparam int ADDR_W     = 19;
   localparam int DQ_W       = 16;
   // register byte offsets
   localparam logic [7:0] REG_CTRL  = 8'h00;
   localparam logic [7:0] REG_ADDR  = 8'h04;
   localparam logic [7:0] REG_WDATA = 8'h08;
   localparam logic [7:0] REG_STAT  = 8'h0c;
   localparam logic [7:0] REG_RDATA = 8'h10;
   // control fields
   localparam int CTRL_GO_BIT    = 4;
   localparam int CTRL_WPROT_BIT = 8;
   localparam int CTRL_RUN_BIT   = 9;
   localparam logic [1:0] CTRL_RST = 2'h2;
   // status register fields
   localparam int STAT_BUSY_BIT = 8;
   localparam int STAT_RYBY_BIT = 9;
   localparam int STAT_ERR_BIT  = 10;
   localparam int STAT_REJ_BIT  = 11;
   // flash status byte positions
   localparam int SB_READY = 7;
   localparam int SB_ESUSP = 6;
   localparam int SB_EERR  = 5;
   localparam int SB_PERR  = 4;
   localparam int SB_VLOW  = 3;
   localparam int SB_PSUSP = 2;
   localparam int SB_PROT  = 1;
   // flash command codes
   localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
   localparam logic [7:0] CMD_READ_STAT  = 8'h70;
   localparam logic [7:0] CMD_CLEAR_STAT = 8'h50;
   localparam logic [7:0] CMD_ERASE      = 8'h20;
   localparam logic [7:0] CMD_CONFIRM    = 8'hd0;
   localparam logic [7:0] CMD_PROG       = 8'h40;
   localparam logic [7:0] CMD_SUSPEND    = 8'hb0;
   localparam logic [1:0] RESP_OKAY      = 2'h0;
   localparam logic [1:0] RESP_SLVERR    = 2'h2;
   typedef enum logic [2:0] {
      OP_STATUS = 3'h0, OP_CLEAR = 3'h1, OP_ERASE = 3'h2, OP_PROG = 3'h3,
      OP_SUSP = 3'h4, OP_RESUME = 3'h5, OP_READ = 3'h6, OP_NONE = 3'h7
   } fsc_op_t;
endpackage
`default_nettype wire

// ===== hdl/fsc_cyc_if.sv
`timescale 1ns/1ps
`default_nettype none
interface fsc_cyc_if;
   import fsc_pkg::*;
   logic              req;
   logic              we;
   logic [ADDR_W-1:0] addr;
   logic [DQ_W-1:0]   wdata;
   logic              done;
   logic [DQ_W-1:0]   rdata;
   modport seq (output req, we, addr, wdata, input done, rdata);
   modport eng (input req, we, addr, wdata, output done, rdata);
endinterface
`default_nettype wire

// ===== hdl/fsc_pincyc.sv
`timescale 1ns/1ps
`default_nettype none
module fsc_pincyc (
   // clock and reset
   input  wire logic                    clk,
   input  wire logic                    rst_n,
   // cycle requests
   fsc_cyc_if.eng                       bus,
   // flash pins
   output logic [fsc_pkg::ADDR_W-1:0]   fl_addr,
   output logic [fsc_pkg::DQ_W-1:0]     fl_dq_o,
   output logic                         fl_dq_oe,
   input  wire logic [fsc_pkg::DQ_W-1:0] fl_dq_i,
   output logic                         fl_ce_n,
   output logic                         fl_oe_n,
   output logic                         fl_we_n
);
   import fsc_pkg::*;
   typedef enum logic [1:0] {E_IDLE = 2'b00, E_SET = 2'b01, E_STB = 2'b11, E_REC = 2'b10} fsc_est_t;
   fsc_est_t          st_q, st_d;
   logic [2:0]        cnt_q, cnt_d;
   logic              we_q, we_d;
   logic [ADDR_W-1:0] addr_q, addr_d;
   logic [DQ_W-1:0]   dout_q, dout_d, rd_q, rd_d, dq_m, dq_s;
   logic              ce_n_d, oe_n_d, we_n_d, oe_d;

   always_comb begin
      st_d   = st_q;
      cnt_d  = cnt_q;
      we_d   = we_q;
      addr_d = addr_q;
      dout_d = dout_q;
      rd_d   = rd_q;
      unique case (st_q)
         E_IDLE: if (bus.req) begin
            st_d   = E_SET;
            we_d   = bus.we;
            addr_d = bus.addr;
            dout_d = bus.wdata;
         end
         E_SET: begin
            st_d  = E_STB;
            cnt_d = 3'(STROBE_CYC - 1);
         end
         E_STB: if (cnt_q == 3'h0) begin
            st_d  = E_REC;
            cnt_d = 3'(RECOV_CYC - 1);
            if (!we_q) rd_d = dq_s;
         end else begin
            cnt_d = cnt_q - 3'h1;
         end
         E_REC: if (cnt_q == 3'h0) st_d = E_IDLE;
                else cnt_d = cnt_q - 3'h1;
      endcase
      // strobes end together with chip enable, so the device latches write data on that edge
      ce_n_d = !(st_d == E_SET || st_d == E_STB);
      oe_n_d = !(st_d == E_STB && !we_d);
      we_n_d = !(st_d == E_STB && we_d);
      oe_d   = we_d && st_d != E_IDLE;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q     <= E_IDLE;
         cnt_q    <= 3'h0;
         we_q     <= 1'b0;
         addr_q   <= '0;
         dout_q   <= '0;
         rd_q     <= '0;
         dq_m     <= '0;
         dq_s     <= '0;
         fl_ce_n  <= 1'b1;
         fl_oe_n  <= 1'b1;
         fl_we_n  <= 1'b1;
         fl_dq_oe <= 1'b0;
      end else begin
         st_q     <= st_d;
         cnt_q    <= cnt_d;
         we_q     <= we_d;
         addr_q   <= addr_d;
         dout_q   <= dout_d;
         rd_q     <= rd_d;
         dq_m     <= fl_dq_i;
         dq_s     <= dq_m;
         fl_ce_n  <= ce_n_d;
         fl_oe_n  <= oe_n_d;
         fl_we_n  <= we_n_d;
         fl_dq_oe <= oe_d;
      end
   end

   assign fl_addr   = addr_q;
   assign fl_dq_o   = dout_q;
   assign bus.rdata = rd_q;
   assign bus.done  = st_q == E_REC && cnt_q == 3'h0;

   property p_strobe_excl;
      @(posedge clk) disable iff (!rst_n) !(!fl_oe_n && !fl_we_n);
   endproperty
   a_strobe_excl: assert property (p_strobe_excl) else $error("read and write strobes low together");

   property p_we_width;
      @(posedge clk) disable iff (!rst_n) $fell(fl_we_n) |-> (!fl_we_n && !fl_ce_n)[*4] ##1 fl_we_n;
   endproperty
   a_we_width: assert property (p_we_width) else $error("write strobe width wrong");

   property p_oe_gap;
      @(posedge clk) disable iff (!rst_n) $rose(fl_oe_n) |-> fl_oe_n && fl_ce_n ##1 fl_oe_n;
   endproperty
   a_oe_gap: assert property (p_oe_gap) else $error("read strobe not returned high between reads");

   property p_done_bound;
      @(posedge clk) disable iff (!rst_n) (st_q == E_IDLE && bus.req) |-> ##6 bus.done;
   endproperty
   a_done_bound: assert property (p_done_bound) else $error("bus cycle did not finish in time");
endmodule
`default_nettype wire

// ===== hdl/fsc_top.sv
// Overview of operation
// - status latched on strobe fall; toggle between reads
// - erase is setup then confirm, same block address
// - program is setup 40 or 10, then data write
// - after suspend write read-status, check suspend bits
`timescale 1ns/1ps
`default_nettype none
module fsc_top (
   // clock and reset
   input  wire logic                      CORE_CLK,
   input  wire logic                      RST_N,
   // axi4-lite slave
   input  wire logic [7:0]                S_AXI_AWADDR,
   input  wire logic                      S_AXI_AWVALID,
   output logic                           S_AXI_AWREADY,
   input  wire logic [31:0]               S_AXI_WDATA,
   input  wire logic [3:0]                S_AXI_WSTRB,
   input  wire logic                      S_AXI_WVALID,
   output logic                           S_AXI_WREADY,
   output logic [1:0]                     S_AXI_BRESP,
   output logic                           S_AXI_BVALID,
   input  wire logic                      S_AXI_BREADY,
   input  wire logic [7:0]                S_AXI_ARADDR,
   input  wire logic                      S_AXI_ARVALID,
   output logic                           S_AXI_ARREADY,
   output logic [31:0]                    S_AXI_RDATA,
   output logic [1:0]                     S_AXI_RRESP,
   output logic                           S_AXI_RVALID,
   input  wire logic                      S_AXI_RREADY,
   // flash pins
   output logic [fsc_pkg::ADDR_W-1:0]     FL_ADDR,
   output logic [fsc_pkg::DQ_W-1:0]       FL_DQ_O,
   output logic                           FL_DQ_OE,
   input  wire logic [fsc_pkg::DQ_W-1:0]  FL_DQ_I,
   output logic                           FL_CE_N,
   output logic                           FL_OE_N,
   output logic                           FL_WE_N,
   input  wire logic                      FL_READY_BUSY_N,
   output logic                           FL_WPROT_N,
   output logic                           FL_RESET_POWERDOWN_N
);
   import fsc_pkg::*;
   typedef enum logic [1:0] {S_IDLE = 2'b00, S_CMD1 = 2'b01, S_CMD2 = 2'b11, S_POLL = 2'b10} fsc_st_t;

   function automatic logic [DQ_W-1:0] cmd16(input logic [7:0] c);
      return {8'h00, c};
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      return a == REG_CTRL || a == REG_ADDR || a == REG_WDATA || a == REG_STAT || a == REG_RDATA;
   endfunction

   fsc_cyc_if cyc ();

   fsc_pincyc u_eng (
      .clk      (CORE_CLK),
      .rst_n    (RST_N),
      .bus      (cyc.eng),
      .fl_addr  (FL_ADDR),
      .fl_dq_o  (FL_DQ_O),
      .fl_dq_oe (FL_DQ_OE),
      .fl_dq_i  (FL_DQ_I),
      .fl_ce_n  (FL_CE_N),
      .fl_oe_n  (FL_OE_N),
      .fl_we_n  (FL_WE_N)
   );

   // axi slave state and software registers
   logic              aw_have_q, aw_have_d, w_have_q, w_have_d;
   logic [7:0]        awaddr_q, awaddr_d;
   logic [31:0]       wd_q, wd_d, rdata_q, rdata_d, rd_mux;
   logic              bvalid_q, bvalid_d, rvalid_q, rvalid_d;
   logic [1:0]        bresp_q, bresp_d, rresp_q, rresp_d;
   logic [1:0]        ctrl_q, ctrl_d;
   logic [ADDR_W-1:0] addr_q, addr_d;
   logic [DQ_W-1:0]   fdata_q, fdata_d;
   logic              wr_fire, go, rej_clr;
   // sequencer state
   fsc_st_t           st_q, st_d;
   fsc_op_t           op_q, op_d;
   logic [7:0]        sts_q, sts_d;
   logic [DQ_W-1:0]   rdat_q, rdat_d;
   logic              rej_q, rej_d, busy, refuse, err, has2, waits;
   logic              ryby_m, ryby_s;

   assign busy = st_q != S_IDLE;
   assign err  = sts_q[SB_EERR] | sts_q[SB_PERR] | sts_q[SB_VLOW] | sts_q[SB_PROT];

   always_comb begin
      unique case (awaddr_q)
         REG_CTRL:  rd_mux = 32'h0;
         default:   rd_mux = 32'h0;
      endcase
      unique case (S_AXI_ARADDR)
         REG_CTRL:  rd_mux = {22'h0, ctrl_q, 5'h0, op_q};
         REG_ADDR:  rd_mux = {13'h0, addr_q};
         REG_WDATA: rd_mux = {16'h0, fdata_q};
         REG_STAT:  rd_mux = {20'h0, rej_q, err, ryby_s, busy, sts_q};
         REG_RDATA: rd_mux = {16'h0, rdat_q};
         default:   rd_mux = 32'h0;
      endcase
   end

   always_comb begin
      aw_have_d = aw_have_q;
      w_have_d  = w_have_q;
      awaddr_d  = awaddr_q;
      wd_d      = wd_q;
      bvalid_d  = bvalid_q;
      bresp_d   = bresp_q;
      rvalid_d  = rvalid_q;
      rdata_d   = rdata_q;
      rresp_d   = rresp_q;
      ctrl_d    = ctrl_q;
      addr_d    = addr_q;
      fdata_d   = fdata_q;
      go        = 1'b0;
      rej_clr   = 1'b0;
      wr_fire   = aw_have_q && w_have_q && !bvalid_q;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
         aw_have_d = 1'b1;
         awaddr_d  = S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
         w_have_d = 1'b1;
         wd_d     = S_AXI_WDATA;
      end
      if (wr_fire) begin
         aw_have_d = 1'b0;
         w_have_d  = 1'b0;
         bvalid_d  = 1'b1;
         bresp_d   = mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
         unique case (awaddr_q)
            REG_CTRL: begin
               ctrl_d = wd_q[CTRL_RUN_BIT:CTRL_WPROT_BIT];
               go     = wd_q[CTRL_GO_BIT];
            end
            // address and data stay put while a sequence runs, so setup and confirm hit one block
            REG_ADDR:  if (!busy) addr_d = wd_q[ADDR_W-1:0];
            REG_WDATA: if (!busy) fdata_d = wd_q[DQ_W-1:0];
            REG_STAT:  rej_clr = wd_q[STAT_REJ_BIT];
            default: ;
         endcase
      end else if (bvalid_q && S_AXI_BREADY) begin
         bvalid_d = 1'b0;
      end
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
         rvalid_d = 1'b1;
         rdata_d  = rd_mux;
         rresp_d  = mapped(S_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_q && S_AXI_RREADY) begin
         rvalid_d = 1'b0;
      end
   end

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         aw_have_q <= 1'b0;
         w_have_q  <= 1'b0;
         awaddr_q  <= 8'h00;
         wd_q      <= 32'h0;
         bvalid_q  <= 1'b0;
         bresp_q   <= RESP_OKAY;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h0;
         rresp_q   <= RESP_OKAY;
         ctrl_q    <= CTRL_RST;
         addr_q    <= '0;
         fdata_q   <= '0;
      end else begin
         aw_have_q <= aw_have_d;
         w_have_q  <= w_have_d;
         awaddr_q  <= awaddr_d;
         wd_q      <= wd_d;
         bvalid_q  <= bvalid_d;
         bresp_q   <= bresp_d;
         rvalid_q  <= rvalid_d;
         rdata_q   <= rdata_d;
         rresp_q   <= rresp_d;
         ctrl_q    <= ctrl_d;
         addr_q    <= addr_d;
         fdata_q   <= fdata_d;
      end
   end

   assign S_AXI_AWREADY        = !aw_have_q;
   assign S_AXI_WREADY         = !w_have_q;
   assign S_AXI_BVALID         = bvalid_q;
   assign S_AXI_BRESP          = bresp_q;
   assign S_AXI_ARREADY        = !rvalid_q;
   assign S_AXI_RVALID         = rvalid_q;
   assign S_AXI_RDATA          = rdata_q;
   assign S_AXI_RRESP          = rresp_q;
   assign FL_WPROT_N           = ctrl_q[0];
   assign FL_RESET_POWERDOWN_N = ctrl_q[1];

   // sequencer: one or two command writes, then status or data reads; clear stops after its one write
   assign has2  = op_q == OP_ERASE || op_q == OP_PROG || op_q == OP_SUSP;
   assign waits = has2;
   // read-array would be ignored while the pin says busy, and clear is dead while suspended
   assign refuse = busy || fsc_op_t'(wd_q[2:0]) == OP_NONE
                || (fsc_op_t'(wd_q[2:0]) == OP_READ && !ryby_s)
                || (fsc_op_t'(wd_q[2:0]) == OP_CLEAR && (sts_q[SB_ESUSP] || sts_q[SB_PSUSP]));

   always_comb begin
      st_d   = st_q;
      op_d   = op_q;
      sts_d  = sts_q;
      rdat_d = rdat_q;
      rej_d  = rej_q;
      if (rej_clr) rej_d = 1'b0;
      if (go && refuse) rej_d = 1'b1;
      unique case (st_q)
         S_IDLE: if (go && !refuse) begin
            op_d = fsc_op_t'(wd_q[2:0]);
            st_d = S_CMD1;
         end
         S_CMD1: if (cyc.done) begin
            if (has2) st_d = S_CMD2;
            else if (op_q == OP_CLEAR) st_d = S_IDLE;
            else st_d = S_POLL;
         end
         S_CMD2: if (cyc.done) st_d = S_POLL;
         S_POLL: if (cyc.done) begin
            if (op_q == OP_READ) rdat_d = cyc.rdata;
            else sts_d = cyc.rdata[7:0];
            // erase, program and suspend keep polling until the ready bit, which also marks a reached suspend
            if (op_q == OP_READ || !waits || cyc.rdata[SB_READY]) st_d = S_IDLE;
         end
      endcase
   end

   always_comb begin
      cyc.req   = st_q != S_IDLE;
      cyc.we    = st_q != S_POLL;
      cyc.addr  = addr_q;
      cyc.wdata = cmd16(CMD_READ_STAT);
      if (st_q == S_CMD1) begin
         unique case (op_q)
            OP_CLEAR:  cyc.wdata = cmd16(CMD_CLEAR_STAT);
            OP_ERASE:  cyc.wdata = cmd16(CMD_ERASE);
            OP_PROG:   cyc.wdata = cmd16(CMD_PROG);
            OP_SUSP:   cyc.wdata = cmd16(CMD_SUSPEND);
            OP_RESUME: cyc.wdata = cmd16(CMD_CONFIRM);
            OP_READ:   cyc.wdata = cmd16(CMD_READ_ARRAY);
            default:   cyc.wdata = cmd16(CMD_READ_STAT);
         endcase
      end else if (st_q == S_CMD2) begin
         unique case (op_q)
            OP_ERASE: cyc.wdata = cmd16(CMD_CONFIRM);
            OP_PROG:  cyc.wdata = fdata_q;
            default:  cyc.wdata = cmd16(CMD_READ_STAT);
         endcase
      end
   end

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         st_q   <= S_IDLE;
         op_q   <= OP_STATUS;
         sts_q  <= 8'h80;
         rdat_q <= '0;
         rej_q  <= 1'b0;
         ryby_m <= 1'b1;
         ryby_s <= 1'b1;
      end else begin
         st_q   <= st_d;
         op_q   <= op_d;
         sts_q  <= sts_d;
         rdat_q <= rdat_d;
         rej_q  <= rej_d;
         ryby_m <= FL_READY_BUSY_N;
         ryby_s <= ryby_m;
      end
   end

   sequence s_cmd1(fsc_op_t o);
      st_q == S_CMD1 && op_q == o;
   endsequence

   property p_erase_seq;
      @(posedge CORE_CLK) disable iff (!RST_N)
         s_cmd1(OP_ERASE) and cyc.done |=> cyc.wdata == cmd16(CMD_CONFIRM) && cyc.addr == FL_ADDR;
   endproperty
   a_erase_seq: assert property (p_erase_seq) else $error("erase confirm missing");

   property p_prog_seq;
      @(posedge CORE_CLK) disable iff (!RST_N)
         s_cmd1(OP_PROG) and cyc.done |-> cyc.wdata == cmd16(CMD_PROG) ##1 st_q == S_CMD2 && cyc.wdata == fdata_q;
   endproperty
   a_prog_seq: assert property (p_prog_seq) else $error("program setup or data wrong");

   property p_clear;
      @(posedge CORE_CLK) disable iff (!RST_N)
         s_cmd1(OP_CLEAR) |-> cyc.we && cyc.wdata == cmd16(CMD_CLEAR_STAT);
   endproperty
   a_clear: assert property (p_clear) else $error("clear command code wrong");

   property p_susp_stat;
      @(posedge CORE_CLK) disable iff (!RST_N)
         s_cmd1(OP_SUSP) and cyc.done |=> cyc.we && cyc.wdata == cmd16(CMD_READ_STAT);
   endproperty
   a_susp_stat: assert property (p_susp_stat) else $error("suspend not followed by status read");

   property p_poll;
      @(posedge CORE_CLK) disable iff (!RST_N)
         st_q == S_POLL && cyc.done && waits && !cyc.rdata[SB_READY] |=> st_q == S_POLL && sts_q[SB_READY] == 1'b0;
   endproperty
   a_poll: assert property (p_poll) else $error("poll ended before ready");

   property p_reject;
      @(posedge CORE_CLK) disable iff (!RST_N)
         go && busy |=> rej_q && $stable(op_q);
   endproperty
   a_reject: assert property (p_reject) else $error("command during busy not refused");
endmodule
`default_nettype wire

// ===== dv/fsc_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module fsc_flash_model #(
   parameter int ERASE_NS = 4000,
   parameter int PROG_NS  = 1000
) (
   // pins from the controller, and vpp_ok from the bench
   input  wire logic [18:0] addr,
   input  wire logic        ce_n,
   input  wire logic        oe_n,
   input  wire logic        we_n,
   input  wire logic [15:0] dq_w,
   input  wire logic        wprot_n,
   input  wire logic        vpp_ok,
   // pins back to the controller
   output logic [15:0]      dq_r,
   output logic             busy_low
);
   logic [15:0] mem [16];
   logic [15:0] lat;
   logic [7:0]  err;
   logic [7:0]  setup;
   logic        stat_mode;
   logic        e_susp;
   logic        p_susp;
   logic        locked;
   logic        sel_w;
   logic [6:0]  blk;
   int          e_left;
   int          p_left;
   assign locked = addr[18:12] == 7'h7f && !wprot_n;
   // a suspended erase waits for any program started meanwhile
   assign busy_low = (p_left > 0 && !p_susp) || (e_left > 0 && !e_susp && p_left == 0);
   // released data lines show the inverse, never a stale match
   assign dq_r = (!ce_n && !oe_n) ? lat : ~lat;
   initial begin
      err = 8'h00; setup = 8'h00; stat_mode = 1'b0; e_susp = 1'b0; p_susp = 1'b0;
      e_left = 0; p_left = 0; lat = 16'h0000; sel_w = 1'b0; blk = 7'h00;
      foreach (mem[i]) mem[i] = 16'hffff;
   end
   always #10 begin
      if (p_left > 0 && !p_susp) p_left = p_left - 10;
      else if (e_left > 0 && !e_susp) e_left = e_left - 10;
   end
   always @(negedge oe_n) begin
      if (!ce_n) lat = stat_mode ? (err | {!busy_low, e_susp, 3'h0, p_susp, 2'h0}) : mem[addr[3:0]];
   end
   // chip enable rises in the same step as the write strobe, so it is judged at the strobe's fall
   always @(negedge we_n) sel_w = !ce_n;
   always @(posedge we_n) begin
      logic [7:0] c;
      c = dq_w[7:0];
      if (!sel_w) c = 8'h00;
      else if (setup == 8'h20) begin
         setup = 8'h00; stat_mode = 1'b1;
         if (c != 8'hd0 || addr[18:12] != blk) err = err | 8'h30;
         else if (!vpp_ok) err = err | 8'h28;
         else if (locked) err = err | 8'h22;
         else begin
            foreach (mem[i]) mem[i] = 16'hffff;
            e_left = ERASE_NS;
         end
      end else if (setup == 8'h40) begin
         setup = 8'h00; stat_mode = 1'b1;
         if (!vpp_ok) err = err | 8'h18;
         else if (locked) err = err | 8'h12;
         else begin
            mem[addr[3:0]] = mem[addr[3:0]] & dq_w;
            p_left = PROG_NS;
         end
      end else if (p_susp && !(c inside {8'hff, 8'h70, 8'hd0})) c = 8'h00;
      else if (e_susp && !(c inside {8'hff, 8'h40, 8'h10, 8'hb0, 8'h70, 8'hd0})) c = 8'h00;
      else case (c)
         8'hff: if (!busy_low) stat_mode = 1'b0;
         8'h70: stat_mode = 1'b1;
         8'h50: if (!e_susp && !p_susp) err = 8'h00;
         8'h20: begin setup = 8'h20; blk = addr[18:12]; end
         8'h40, 8'h10: setup = 8'h40;
         8'hb0: begin
            stat_mode = 1'b1;
            if (p_left > 0 && !p_susp) p_susp = 1'b1;
            else if (e_left > 0 && !e_susp) e_susp = 1'b1;
         end
         8'hd0: begin
            stat_mode = 1'b1;
            if (p_susp) p_susp = 1'b0;
            else e_susp = 1'b0;
         end
         default: err = err | 8'h30;
      endcase
   end
endmodule
`default_nettype wire

// ===== dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import fsc_pkg::*;
   logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready, vpp_ok;
   logic        awready, wready, bvalid, arready, rvalid, dq_oe, ce_n, oe_n, we_n, busy_low, ryby_n, wprot_n, rpd_n;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, s;
   logic [1:0]  bresp, rresp, r;
   logic [18:0] fl_addr;
   logic [15:0] dq_o, dq_i;
   int          failures, checked, k;
   // open-drain ready pin with pull-up
   assign ryby_n = busy_low ? 1'b0 : 1'b1;
   fsc_top DUT (.CORE_CLK(clk), .RST_N(rst_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
      .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid),
      .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
      .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .FL_ADDR(fl_addr), .FL_DQ_O(dq_o),
      .FL_DQ_OE(dq_oe), .FL_DQ_I(dq_i), .FL_CE_N(ce_n), .FL_OE_N(oe_n), .FL_WE_N(we_n),
      .FL_READY_BUSY_N(ryby_n), .FL_WPROT_N(wprot_n), .FL_RESET_POWERDOWN_N(rpd_n));
   fsc_flash_model flash (.addr(fl_addr), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .dq_w(dq_o),
      .wprot_n(wprot_n), .vpp_ok(vpp_ok), .dq_r(dq_i), .busy_low(busy_low));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      if (failures == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic hang();
      failures++;
      $display("Error at %0t: wait ran out", $time);
      give_verdict();
   endtask
   // sampling on the falling edge sees what the next rising edge takes
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rsp);
      int n;
      logic aw, w, b;
      @(posedge clk) {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
      for (n = 0; n < 50; n++) begin
         @(negedge clk) {aw, w, b, rsp} = {awvalid & awready, wvalid & wready, bvalid & bready, bresp};
         @(posedge clk) if (aw) awvalid <= 1'b0;
         if (w) wvalid <= 1'b0;
         if (b) bready <= 1'b0;
         if (b) break;
      end
      if (n == 50) hang();
   endtask
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rsp);
      int n;
      logic ar, rv;
      @(posedge clk) {araddr, arvalid, rready} <= {a, 2'h3};
      for (n = 0; n < 50; n++) begin
         @(negedge clk) {ar, rv, d, rsp} = {arvalid & arready, rvalid & rready, rdata, rresp};
         @(posedge clk) if (ar) arvalid <= 1'b0;
         if (rv) rready <= 1'b0;
         if (rv) break;
      end
      if (n == 50) hang();
   endtask
   task automatic go(input logic [2:0] op, input logic [18:0] a, input logic [15:0] d, input logic run);
      int n;
      axi_wr(REG_ADDR, {13'h0, a}, r);
      axi_wr(REG_WDATA, {16'h0, d}, r);
      axi_wr(REG_CTRL, {22'h0, 2'h2, 3'h0, 1'b1, 1'b0, op}, r);
      for (n = 0; n < 600 && run; n++) begin
         axi_rd(REG_STAT, s, r);
         if (s[STAT_BUSY_BIT] === 1'b0) break;
      end
      if (n == 600) hang();
   endtask
   task automatic t_reset();
      axi_rd(REG_STAT, s, r);
      chk(s[7:0], 8'h80);
      chk({wprot_n, rpd_n}, 2'b01);
      axi_rd(8'h20, s, r);
      chk(r, RESP_SLVERR);
      chk(s, 32'h0);
      axi_wr(8'h24, 32'h1, r);
      chk(r, RESP_SLVERR);
   endtask
   task automatic t_prog_erase();
      go(3'h3, 19'h3, 16'h1234, 1'b1);
      chk({ryby_n, s[7:0]}, 9'h180);
      go(3'h6, 19'h3, 16'h0, 1'b1);
      axi_rd(REG_RDATA, s, r);
      chk(s[15:0], 16'h1234);
      go(3'h3, 19'h3, 16'hff00, 1'b1);
      go(3'h6, 19'h3, 16'h0, 1'b1);
      axi_rd(REG_RDATA, s, r);
      chk(s[15:0], 16'h1200);
      go(3'h2, 19'h3, 16'h0, 1'b1);
      chk(s[7:0], 8'h80);
      go(3'h6, 19'h3, 16'h0, 1'b1);
      axi_rd(REG_RDATA, s, r);
      chk(s[15:0], 16'hffff);
   endtask
   task automatic t_errors();
      logic [31:0] tbl [4];
      logic [8:0]  want;
      tbl = '{{8'h0, 4'h0, 19'h3, 1'b0}, {8'h0, 4'h1, 19'h3, 1'b0}, {8'h0, 4'h0, 19'h7f000, 1'b1},
             {8'h0, 4'h1, 19'h7f000, 1'b1}};
      for (k = 0; k < 4; k++) begin
         @(posedge clk) vpp_ok <= tbl[k][0];
         go(tbl[k][20] ? 3'h3 : 3'h2, tbl[k][19:1], 16'h0, 1'b1);
         want = {1'b1, 8'h80 | (tbl[k][20] ? 8'h10 : 8'h20) | (tbl[k][0] ? 8'h02 : 8'h08)};
         chk({s[STAT_ERR_BIT], s[7:0]}, want);
         go(3'h1, 19'h0, 16'h0, 1'b1);
         go(3'h0, 19'h0, 16'h0, 1'b1);
         chk({s[STAT_ERR_BIT], s[7:0]}, 9'h080);
      end
   endtask
   task automatic t_refuse();
      go(3'h2, 19'h3, 16'h0, 1'b0);
      go(3'h4, 19'h0, 16'h0, 1'b1);
      chk({s[STAT_REJ_BIT], s[7:0]}, 9'h180);
      axi_wr(REG_STAT, 32'h800, r);
      go(3'h7, 19'h0, 16'h0, 1'b0);
      axi_rd(REG_STAT, s, r);
      chk(s[STAT_REJ_BIT], 1'b1);
      axi_wr(REG_STAT, 32'h800, r);
      go(3'h4, 19'h0, 16'h0, 1'b1);
      chk({s[STAT_REJ_BIT], s[7:0]}, 9'h080);
      go(3'h5, 19'h0, 16'h0, 1'b1);
      chk({ryby_n, s[7:0]}, 9'h180);
   endtask
   initial begin
      {rst_n, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
      {vpp_ok, failures, checked} = {1'b1, 64'h0};
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_prog_erase();
      t_errors();
      t_refuse();
      give_verdict();
   end
endmodule
`default_nettype wire
